//--- mpp_port.v
/*
 * Multiplexed parallel memory port: drives an asynchronous memory over a
 * shared 16-bit address/data bus with latch, read and write strobes.
 * Assumes requests from the core port and the DMA unit arrive on the same
 * clock; read data and the pad input arrive asynchronously from pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mpp_map.vh"
module mpp_port (
  input  wire        clk,
  input  wire        resetn,
  input  wire        cfgWide,
  input  wire        cfgLatchLow,
  input  wire        cfgFlagMode,
  input  wire [4:0]  cfgDataCycles,
  input  wire        coreValid,
  output wire        coreReady,
  input  wire        coreWrite,
  input  wire [23:0] coreAddr,
  input  wire [15:0] coreWdata,
  input  wire        dmaValid,
  output wire        dmaReady,
  input  wire        dmaWrite,
  input  wire [23:0] dmaAddr,
  input  wire [15:0] dmaWdata,
  output reg         rdValid_ff,
  output reg  [15:0] rdData_ff,
  output reg         rdFromDma_ff,
  input  wire [15:0] busIn,
  output reg  [15:0] busOut_ff,
  output reg  [15:0] busOe_ff,
  output reg         latchStrobe_ff,
  output reg         readStrobeN_ff,
  output reg         writeStrobeN_ff
);
  // ************************************************************
  // States, one-hot.
  // ************************************************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ADDR = 5'h02;
  localparam [4:0] ST_HOLD = 5'h04;
  localparam [4:0] ST_DATA = 5'h08;
  localparam [4:0] ST_DONE = 5'h10;

  // ************************************************************
  // Request arbitration and buffering.
  // ************************************************************
  wire [41:0] reqData;   // {fromDma, write, addr, wdata}.
  wire        reqValid;
  wire        reqReady;  // Back-pressure to both sources.
  wire [41:0] qData;
  wire        qValid;
  reg         qTake;     // Drain strobe from the state machine.
  wire        pickDma;

  // core or DMA source. Core wins a tie; DMA waits behind it.
  assign pickDma   = dmaValid & ~coreValid;
  assign reqValid  = coreValid | dmaValid;
  assign reqData   = pickDma ? {1'b1, dmaWrite, dmaAddr, dmaWdata}
                             : {1'b0, coreWrite, coreAddr, coreWdata};
  assign coreReady = reqReady;
  assign dmaReady  = reqReady & ~coreValid;

  mpp_fifo #(
    .WIDTH (`MPP_REQ_W),
    .DEPTH (`MPP_FIFO_DEPTH),
    .AW    (`MPP_FIFO_AW)
  ) u_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .inData   (reqData),
    .inValid  (reqValid),
    .inReady  (reqReady),
    .outData  (qData),
    .outValid (qValid),
    .outReady (qTake)
  );

  // ************************************************************
  // Pad input synchroniser.
  // ************************************************************
  reg [15:0] busMeta_ff;  // First stage, read only by the second.
  reg [15:0] busSync_ff;  // Second stage, safe to use.

  // Two flops ahead of any use of the pad data.
  always @(posedge clk) begin
    if (!resetn) begin
      busMeta_ff <= 16'h0000;
      busSync_ff <= 16'h0000;
    end else begin
      busMeta_ff <= busIn;
      busSync_ff <= busMeta_ff;
    end
  end

  // ************************************************************
  // Transfer state.
  // ************************************************************
  reg  [4:0]  state_ff;       // Current state.
  reg  [4:0]  cnt_ff;         // Phase cycle counter.
  reg  [15:0] upper_ff;       // Upper address last latched externally.
  reg         upperValid_ff;  // Upper copy is meaningful.
  reg         curWrite_ff;    // Current access is a write.
  reg         curDma_ff;      // Current access came from DMA.
  reg  [15:0] curWdata_ff;    // Write data of the current access.
  reg         latchPol_ff;    // Active level of the latch strobe.
  wire        qDma   = qData[41];
  wire        qWrite = qData[40];
  wire [23:0] qAddr  = qData[39:16];
  wire [15:0] qWdata = qData[15:0];
  wire        needAddr;
  wire [4:0]  dataLen;

  // upper-change detect. Byte mode re-latches only when UPPER_ADDRESS_BITS moves or upperValid_ff is clear.
  // external latch holds. Once latched the upper bits need no refresh.
  assign needAddr = cfgWide | ~upperValid_ff |
                    (upper_ff != qAddr[`MPP_UPPER_MSB:`MPP_UPPER_LSB]);
  // At least two data cycles are always given to the memory.
  assign dataLen  = (cfgDataCycles < 5'h02) ? 5'h02 : cfgDataCycles;

  always @* begin
    qTake = state_ff[0] & qValid & ~cfgFlagMode;
  end

  // Main sequencer. Flag mode parks the port with all strobes idle.
  always @(posedge clk) begin
    if (!resetn) begin
      // reset pin states. Strobes high, latch low, bus released.
      state_ff        <= ST_IDLE;
      cnt_ff          <= 5'h00;
      upper_ff        <= 16'h0000;
      upperValid_ff   <= 1'b0;
      curWrite_ff     <= 1'b0;
      curDma_ff       <= 1'b0;
      curWdata_ff     <= 16'h0000;
      // latch polarity. Active high until software asks otherwise.
      latchPol_ff     <= `MPP_LATCH_RST_POL;
      busOut_ff       <= 16'h0000;
      busOe_ff        <= 16'h0000;
      latchStrobe_ff  <= 1'b0;
      readStrobeN_ff  <= `MPP_STROBE_IDLE;
      writeStrobeN_ff <= `MPP_STROBE_IDLE;
      rdValid_ff      <= 1'b0;
      rdData_ff       <= 16'h0000;
      rdFromDma_ff    <= 1'b0;
    end else begin
      rdValid_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          // Polarity changes only between accesses to avoid runt pulses.
          latchPol_ff    <= ~cfgLatchLow;
          latchStrobe_ff <= cfgLatchLow;
          busOe_ff       <= 16'h0000;
          // flags hold strobes. Nothing is started in flag mode.
          if (qTake) begin
            curWrite_ff <= qWrite;
            curDma_ff   <= qDma;
            curWdata_ff <= qWdata;
            if (needAddr) begin
              // address phase. Latch strobe marks address on the bus.
              // strobe each address. full 16-bit address when wide.
              busOut_ff      <= cfgWide ? qAddr[15:0] : qAddr[`MPP_UPPER_MSB:`MPP_UPPER_LSB];
              busOe_ff       <= 16'hffff;
              latchStrobe_ff <= latchPol_ff;
              upper_ff       <= qAddr[`MPP_UPPER_MSB:`MPP_UPPER_LSB];
              upperValid_ff  <= ~cfgWide;
              cnt_ff         <= 5'h00;
              state_ff       <= ST_ADDR;
            end else begin
              // Byte mode reuse: low address byte is driven for the one hold cycle ahead of the data phase.
              busOut_ff <= {8'h00, qAddr[7:0]};
              busOe_ff  <= 16'h00ff;
              cnt_ff    <= 5'h00;
              state_ff  <= ST_HOLD;
            end
          end
        end
        ST_ADDR: begin
          if (cnt_ff >= (`MPP_ALE_CYC - 1)) begin
            // address before data. Latch drops a cycle ahead of strobes.
            latchStrobe_ff <= ~latchPol_ff;
            cnt_ff         <= 5'h00;
            state_ff       <= ST_HOLD;
          end else begin
            cnt_ff <= cnt_ff + 5'h01;
          end
        end
        ST_HOLD: begin
          cnt_ff   <= 5'h00;
          state_ff <= ST_DATA;
          // width modes. Byte mode only drives the low lane for data.
          if (curWrite_ff) begin
            busOut_ff       <= cfgWide ? curWdata_ff : {8'h00, curWdata_ff[7:0]};
            busOe_ff        <= cfgWide ? 16'hffff : 16'h00ff;
            writeStrobeN_ff <= 1'b0;
          end else begin
            busOe_ff       <= 16'h0000;
            readStrobeN_ff <= 1'b0;
          end
        end
        ST_DATA: begin
          if (cnt_ff >= (dataLen - 5'h01)) begin
            readStrobeN_ff  <= `MPP_STROBE_IDLE;
            writeStrobeN_ff <= `MPP_STROBE_IDLE;
            state_ff        <= ST_DONE;
          end else begin
            cnt_ff <= cnt_ff + 5'h01;
          end
        end
        ST_DONE: begin
          // Sampled data has passed the two-flop stage during the strobe.
          if (!curWrite_ff) begin
            rdValid_ff   <= 1'b1;
            rdData_ff    <= cfgWide ? busSync_ff : {8'h00, busSync_ff[7:0]};
            rdFromDma_ff <= curDma_ff;
          end
          busOe_ff <= 16'h0000;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- mpp_map.vh
/*
 * Constants for the multiplexed parallel memory port: the address-phase and
 * hold timing counts, the width modes and the idle pin levels.
 * Assumes it is included by bare name from the port's design files.
 */
// Notes on behaviour
// - Multiplex address and data, latch strobe marks phase.
// - Support 8-bit and 16-bit data modes.
// - 8-bit mode: latch when upper address changes.
// - Read strobe low only during reads.
// - Write strobe low only during writes.
// - 16-bit mode: latch strobe on every new address.
// - Latch polarity high after reset, software-selectable.
// - Flag mode holds all strobes deasserted.
// - Reset: strobes high, latch low, bus undriven.
// - Port or DMA may source address/data.
`ifndef MPP_MAP_VH
`define MPP_MAP_VH

// ************************************************************
// Timing counts, in cycles of the 50 ns clock.
// ************************************************************
`define MPP_CLK_NS        50
`define MPP_ALE_NS        50
`define MPP_ALE_CYC       ((`MPP_ALE_NS + `MPP_CLK_NS - 1) / `MPP_CLK_NS)
`define MPP_HOLD_CYC      1

// ************************************************************
// Modes and field positions.
// ************************************************************
`define MPP_MODE_8        1'b0
`define MPP_MODE_16       1'b1
`define MPP_UPPER_MSB     23
`define MPP_UPPER_LSB     8
`define MPP_FIFO_DEPTH    4
`define MPP_FIFO_AW       2
`define MPP_REQ_W         42

// ************************************************************
// Idle pin levels.
// ************************************************************
`define MPP_STROBE_IDLE   1'b1
`define MPP_LATCH_RST_POL 1'b1

`endif

//--- mpp_fifo.v
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module mpp_fifo #(
  parameter WIDTH = 42,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  // ************************************************************
  // Storage and pointers.
  // ************************************************************
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1]; // Entry storage.
  reg [AW-1:0]    wrPtr_ff;           // Next slot to fill.
  reg [AW-1:0]    rdPtr_ff;           // Next slot to drain.
  reg [AW:0]      count_ff;           // Entries held.
  wire            doWr;
  wire            doRd;

  assign inReady  = (count_ff != DEPTH[AW:0]);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign outData  = mem_ff[rdPtr_ff];
  assign doWr     = inValid & inReady;
  assign doRd     = outValid & outReady;

  // Pointer and count update; the count is honest, so a stalled drain fills it.
  always @(posedge clk) begin
    if (!resetn) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doRd) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      if (doWr && !doRd) begin
        count_ff <= count_ff + 1'b1;
      end else if (doRd && !doWr) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // Data storage needs no reset.
  always @(posedge clk) begin
    if (doWr) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end
endmodule
`default_nettype wire

//--- mpp_port_asserts.sv
/* Pin checker for the multiplexed parallel memory port.
   Assumes it is bound onto mpp_port, one clock and a synchronous low reset. */
`timescale 1ns/1ps
`default_nettype none
module mpp_port_asserts (
  input wire        clk,
  input wire        resetn,
  input wire        cfgLatchLow,
  input wire        cfgFlagMode,
  input wire [4:0]  cfgDataCycles,
  input wire        rdValid_ff,
  input wire [15:0] busOe_ff,
  input wire        latchStrobe_ff,
  input wire        readStrobeN_ff,
  input wire        writeStrobeN_ff
);
  // Latch strobe active in the selected polarity; quiet means no strobe active.
  wire latchOn = latchStrobe_ff != cfgLatchLow;
  wire quiet   = readStrobeN_ff && writeStrobeN_ff && !latchOn;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Reset is the antecedent here, so this one must not be disabled by it.
  a_reset_idle: assert property (disable iff (1'b0) !resetn |=> readStrobeN_ff && writeStrobeN_ff
    && !latchStrobe_ff && busOe_ff == 16'h0000) else $error("pins not idle under reset");
  a_strobe_excl: assert property (readStrobeN_ff || writeStrobeN_ff) else $error("both strobes low");
  a_read_float: assert property (!readStrobeN_ff |-> busOe_ff == 16'h0000) else $error("bus driven in read");
  a_latch_alone: assert property (latchOn |-> quiet || (readStrobeN_ff && writeStrobeN_ff))
    else $error("latch overlaps data strobe");
  a_addr_drive: assert property ($rose(latchOn) && $stable(cfgLatchLow) |-> busOe_ff == 16'hffff)
    else $error("address phase not driven");
  a_latch_pulse: assert property (latchOn && busOe_ff == 16'hffff |=> !latchOn) else $error("latch too long");
  a_flag_quiet: assert property ((cfgFlagMode && quiet) [*3] |=> quiet) else $error("access in flag mode");
  a_read_answer: assert property ($rose(readStrobeN_ff) |=> rdValid_ff) else $error("no read data pulse");
  a_valid_pulse: assert property (rdValid_ff |=> !rdValid_ff) else $error("read pulse too long");
  a_read_len: assert property ($fell(readStrobeN_ff) && cfgDataCycles == 5'h03 |->
    !readStrobeN_ff [*3] ##1 readStrobeN_ff) else $error("read strobe length");
  a_write_len: assert property ($fell(writeStrobeN_ff) && cfgDataCycles == 5'h03 |->
    !writeStrobeN_ff [*3] ##1 writeStrobeN_ff) else $error("write strobe length");
  c_read: cover property ($rose(rdValid_ff));
  c_write: cover property ($fell(writeStrobeN_ff));
  c_low_latch: cover property (cfgLatchLow && latchOn);
endmodule
bind mpp_port mpp_port_asserts chk (.clk, .resetn, .cfgLatchLow, .cfgFlagMode, .cfgDataCycles, .rdValid_ff,
  .busOe_ff, .latchStrobe_ff, .readStrobeN_ff, .writeStrobeN_ff);
`default_nettype wire

//--- mpp_mem_model.sv
/* Asynchronous memory with an external address latch, pull-ups on the bus.
   Assumes it sees the port's pins directly; word index is latched bits 7:0. */
`timescale 1ns/1ps
`default_nettype none
module mpp_mem_model (
  input  wire        clk,
  input  wire        cfgLatchLow,
  input  wire [15:0] busOut,
  input  wire [15:0] busOe,
  input  wire        latchStrobe,
  input  wire        readStrobeN,
  input  wire        writeStrobeN,
  output wire [15:0] busIn
);
  logic [15:0] mem [0:255];       // Storage, left unknown until written.
  logic [15:0] latched = 16'h0000; // External latch contents.
  // latch then store: the latch holds the address while data moves.
  always @(posedge clk) begin
    if (latchStrobe != cfgLatchLow) latched <= busIn;
    if (!writeStrobeN) mem[latched[7:0]] <= busIn;
  end
  // Undriven bits read as the pull-up level, so stale data cannot pass.
  assign busIn = !readStrobeN ? mem[latched[7:0]] : (busOut & busOe) | ~busOe;
endmodule
`default_nettype wire

//--- tb_top.sv
/* Self-checking bench for the parallel memory port with a memory model.
   Assumes a 20 MHz clock; inputs change on the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0, resetn = 1'b0, cfgWide = 1'b1, cfgLatchLow = 1'b0, cfgFlagMode = 1'b0;
  logic        coreValid = 1'b0, coreWrite = 1'b0, dmaValid = 1'b0, dmaWrite = 1'b0;
  logic [23:0] coreAddr = 24'h000000, dmaAddr = 24'h000000;
  logic [4:0]  cfgDataCycles = 5'h03;
  logic [15:0] coreWdata = 16'h0000, dmaWdata = 16'h0000, rdData, busIn, busOut, busOe, addrSeen;
  wire         coreReady, dmaReady, rdValid, rdFromDma, latchStrobe, readStrobeN, writeStrobeN;
  int          errors = 0, total_checks = 0, cycles = 0, latchCnt = 0, strobeCnt = 0;
  mpp_port dut (.clk(clk), .resetn(resetn), .cfgWide(cfgWide), .cfgLatchLow(cfgLatchLow),
    .cfgFlagMode(cfgFlagMode), .cfgDataCycles(cfgDataCycles), .coreValid(coreValid), .coreReady(coreReady),
    .coreWrite(coreWrite), .coreAddr(coreAddr), .coreWdata(coreWdata), .dmaValid(dmaValid),
    .dmaReady(dmaReady), .dmaWrite(dmaWrite), .dmaAddr(dmaAddr), .dmaWdata(dmaWdata), .rdValid_ff(rdValid),
    .rdData_ff(rdData), .rdFromDma_ff(rdFromDma), .busIn(busIn), .busOut_ff(busOut), .busOe_ff(busOe),
    .latchStrobe_ff(latchStrobe), .readStrobeN_ff(readStrobeN), .writeStrobeN_ff(writeStrobeN));
  mpp_mem_model mem (.clk(clk), .cfgLatchLow(cfgLatchLow), .busOut(busOut), .busOe(busOe),
    .latchStrobe(latchStrobe), .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .busIn(busIn));
  always #25 clk = ~clk;
  // Pin monitor: latch pulses, last latched address, strobe cycles, and the hang limit.
  always @(negedge clk) begin
    cycles++;
    if (latchStrobe !== cfgLatchLow) begin
      latchCnt++;
      addrSeen = busOut;
    end
    if (readStrobeN !== 1'b1 || writeStrobeN !== 1'b1) strobeCnt++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One request held until the edge where ready is high, then released.
  task automatic push(input logic dma, input logic wr, input logic [23:0] a, input logic [15:0] d);
    int n;
    @(negedge clk);
    {coreValid, dmaValid} = {!dma, dma};
    {coreWrite, dmaWrite, coreAddr, dmaAddr, coreWdata, dmaWdata} = {wr, wr, a, a, d, d};
    n = 0;
    while ((dma ? dmaReady : coreReady) !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    {coreValid, dmaValid} = 2'b00;
  endtask
  task automatic rd(input logic dma, input logic [23:0] a, input logic [15:0] exp);
    int n;
    push(dma, 1'b0, a, 16'h0000);
    n = 0;
    while (rdValid !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(rdData, exp);
    check({15'h0000, rdFromDma}, {15'h0000, dma});
  endtask
  task automatic t_reset;
    check({13'h0000, readStrobeN, writeStrobeN, latchStrobe}, 16'h0006);
    check(busOe, 16'h0000);
    $display("t_reset done");
  endtask
  task automatic t_wide;
    push(1'b0, 1'b1, 24'h000012, 16'ha5c3);
    rd(1'b0, 24'h000012, 16'ha5c3);
    check(addrSeen, 16'h0012);
    push(1'b1, 1'b1, 24'h000040, 16'h1357);
    rd(1'b1, 24'h000040, 16'h1357);
    $display("t_wide done");
  endtask
  task automatic t_byte;
    int n;
    @(negedge clk) cfgWide = 1'b0;
    n = latchCnt;
    push(1'b0, 1'b1, 24'h123400, 16'h005a);
    rd(1'b0, 24'h123400, 16'h005a);
    check(16'(latchCnt - n), 16'h0001);
    push(1'b0, 1'b1, 24'h567800, 16'h00c3);
    rd(1'b0, 24'h567800, 16'h00c3);
    check(16'(latchCnt - n), 16'h0002);
    check(addrSeen, 16'h5678);
    @(negedge clk) cfgWide = 1'b1;
    $display("t_byte done");
  endtask
  task automatic t_polarity;
    int n, s;
    @(negedge clk) cfgLatchLow = 1'b1;
    // A request below the two-cycle floor must still get a two-cycle strobe.
    cfgDataCycles = 5'h01;
    repeat (3) @(negedge clk);
    check({15'h0000, latchStrobe}, 16'h0001);
    n = latchCnt;
    s = strobeCnt;
    rd(1'b0, 24'h000012, 16'ha5c3);
    check(16'(latchCnt - n), 16'h0001);
    check(16'(strobeCnt - s), 16'h0002);
    @(negedge clk) cfgLatchLow = 1'b0;
    cfgDataCycles = 5'h03;
    repeat (3) @(negedge clk);
    $display("t_polarity done");
  endtask
  // Flag mode queues requests until the four-word buffer refuses, then drains.
  task automatic t_flag;
    int n, i;
    @(negedge clk) cfgFlagMode = 1'b1;
    n = strobeCnt;
    for (i = 0; i < 4; i++) push(1'b0, 1'b1, 24'(i + 32), 16'(i + 16'hc000));
    check({15'h0000, coreReady}, 16'h0000);
    repeat (10) @(negedge clk);
    check(16'(strobeCnt - n), 16'h0000);
    check({15'h0000, latchStrobe}, 16'h0000);
    cfgFlagMode = 1'b0;
    for (i = 0; i < 4; i++) rd(1'b0, 24'(i + 32), 16'(i + 16'hc000));
    $display("t_flag done");
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (9) @(negedge clk);
    t_reset();
    @(negedge clk) resetn = 1'b1;
    @(negedge clk);
    t_reset();
    t_wide();
    t_byte();
    t_polarity();
    t_flag();
    stop_test();
  end
endmodule
`default_nettype wire
